// ===== profile_select_pkg.sv
// Constants, register map and carrier types for the oscillator profile selector
package profile_select_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam int PROF_W = 4;
    localparam int PHASE_W = 48;
    localparam int NUM_PROFILES = 16;
    // Register offsets
    localparam logic [11:0] PROFILE_SELECT_CONTROL_OFS = 12'h354;
    localparam logic [11:0] PHASE_UPDATE_CONTROL_OFS = 12'h355;
    localparam logic [11:0] INCREMENT_BASE_OFS = 12'h356;
    localparam logic [11:0] OFFSET_BASE_OFS = 12'h35D;
    localparam logic [11:0] UPDATE_CONTROL_OFS = 12'h363;
    localparam logic [11:0] TRANSFER_CMD_OFS = 12'h364;
    localparam logic [11:0] ACTIVE_STATUS_OFS = 12'h365;
    localparam logic [11:0] REGISTER_INDEX_OFS = 12'h314;
    localparam logic [2:0] PHASE_BYTES = 3'h6;
    // Field positions
    localparam int MODE_LSB = 4;
    localparam int LIMIT_LSB = 0;
    localparam int TRANSFER_BIT = 0;
    localparam int CONTINUOUS_BIT = 0;
    // Reset values
    localparam logic [7:0] PROFILE_SELECT_CONTROL_RST = 8'h00;
    localparam logic [3:0] PHASE_INDEX_RST = 4'h0;
    localparam logic [3:0] REGISTER_INDEX_RST = 4'h0;
    localparam logic UPDATE_CONTINUOUS_RST = 1'b1;
    localparam logic [3:0] COUNTER_RST = 4'h0;
    // Select-mode encodings
    localparam logic [3:0] MODE_REGISTER = 4'h0;
    localparam logic [3:0] MODE_B0_A0 = 4'h1;
    localparam logic [3:0] MODE_B1_A1 = 4'h2;
    localparam logic [3:0] MODE_A1_A0 = 4'h3;
    localparam logic [3:0] MODE_B1_B0 = 4'h4;
    localparam logic [3:0] MODE_B1A1B0A0 = 4'h5;
    localparam logic [3:0] MODE_B1B0A1A0 = 4'h6;
    localparam logic [3:0] MODE_EDGE_A0 = 4'h8;
    localparam logic [3:0] MODE_EDGE_B1 = 4'hB;

    // The four select pins as one bundle
    typedef struct packed {
        logic b_one;
        logic b_zero;
        logic a_one;
        logic a_zero;
    } select_pins_type;

    // Register bus request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } reg_req_type;

    // One profile's phase settings
    typedef struct packed {
        logic [PHASE_W-1:0] increment;
        logic [PHASE_W-1:0] offset;
    } profile_phase_type;
endpackage

// ===== select_pin_sync.sv
// Two-stage synchroniser and rising-edge detector for the profile select pins
`timescale 1ns/1ps
module select_pin_sync (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire profile_select_pkg::select_pins_type pins_i,
    output profile_select_pkg::select_pins_type level_o,
    output profile_select_pkg::select_pins_type rise_o
);
    import profile_select_pkg::*;

    select_pins_type meta_reg;
    select_pins_type sync_reg;
    select_pins_type prev_reg;

    // The first stage is read only by the second stage
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_reg <= '0;
            sync_reg <= '0;
            prev_reg <= '0;
        end else begin
            meta_reg <= pins_i;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    // Edges come from the settled copies only
    assign level_o = sync_reg;
    assign rise_o = sync_reg & ~prev_reg;
endmodule

// ===== nco_profile_select.sv
// Oscillator profile selector for the second downconverter: index source, edge counter, phase tables
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps

// Notes on behaviour
// - Mode field selects index source; mode zero uses the register index field.
// - Mode 1 gives 00,B0,A0; mode 2 gives 00,B1,A1.
// - Mode 3 gives 00,A1,A0; mode 4 gives 00,B1,B0.
// - Mode 5 gives B1,A1,B0,A0; mode 6 gives B1,B0,A1,A0.
// - Modes 8 to 11 count rising edges of A0, A1, B0, B1; count is index.
// - In edge modes the counter counts up to the programmed limit field, then wraps to zero on the next edge.
// - Limit field is binary profile 0 to 15, reset zero.
// - Phase index field picks which profile phase writes load; upper bits read zero.
// - Phase writes apply continuously or only after a transfer command.
// - Each profile holds a 48-bit increment and offset.
module nco_profile_select #(
    parameter int NUM_PROF = profile_select_pkg::NUM_PROFILES
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic [profile_select_pkg::ADDR_W-1:0] addr_i,
    input wire logic [profile_select_pkg::DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [profile_select_pkg::DATA_W-1:0] rdata_o,
    input wire profile_select_pkg::select_pins_type select_pins_i,
    output logic [profile_select_pkg::PROF_W-1:0] active_profile_o,
    output logic [profile_select_pkg::PHASE_W-1:0] active_increment_o,
    output logic [profile_select_pkg::PHASE_W-1:0] active_offset_o
);
    import profile_select_pkg::*;

    // Byte lane within a 48-bit word, -1 when outside the range
    function automatic logic [3:0] byte_lane(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] base);
        logic [ADDR_W-1:0] d;
        d = a - base;
        byte_lane = (d < {9'h000, PHASE_BYTES}) ? {1'b0, d[2:0]} : 4'hF;
    endfunction

    // Replace one byte of a 48-bit word
    function automatic logic [PHASE_W-1:0] put_byte(input logic [PHASE_W-1:0] w, input logic [2:0] lane,
                                                   input logic [DATA_W-1:0] b);
        logic [PHASE_W-1:0] r;
        r = w;
        r[lane*8 +: 8] = b;
        put_byte = r;
    endfunction

    typedef enum {CNT_IDLE, CNT_RUN} count_state_type;

    reg_req_type req;
    select_pins_type pin_level;
    select_pins_type pin_rise;
    logic [7:0] select_control_reg;
    logic [3:0] phase_index_reg;
    logic [3:0] register_index_reg;
    logic continuous_reg;
    logic [3:0] counter_reg;
    logic [3:0] counter_next;
    count_state_type count_state_reg;
    logic [PHASE_W-1:0] stage_inc_reg;
    logic [PHASE_W-1:0] stage_ofs_reg;
    profile_phase_type table_reg [NUM_PROF];
    logic [3:0] active_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic [PHASE_W-1:0] inc_out_reg;
    logic [PHASE_W-1:0] ofs_out_reg;

    assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

    // Pins cross into this clock before anyone looks at them
    select_pin_sync u_sync (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .pins_i(select_pins_i),
        .level_o(pin_level),
        .rise_o(pin_rise)
    );

    // Field decode
    wire [3:0] mode = select_control_reg[MODE_LSB +: 4];
    wire [3:0] limit = select_control_reg[LIMIT_LSB +: 4];
    wire edge_mode = mode[3] && (mode[2] == 1'b0);
    wire [1:0] edge_sel = mode[1:0];
    wire edge_seen = edge_mode && pin_rise[edge_sel];
    wire [3:0] inc_lane = byte_lane(req.addr, INCREMENT_BASE_OFS);
    wire [3:0] ofs_lane = byte_lane(req.addr, OFFSET_BASE_OFS);
    wire wr_ctrl = req.wr && (req.addr == PROFILE_SELECT_CONTROL_OFS);
    wire wr_phase_idx = req.wr && (req.addr == PHASE_UPDATE_CONTROL_OFS);
    wire wr_reg_idx = req.wr && (req.addr == REGISTER_INDEX_OFS);
    wire wr_update = req.wr && (req.addr == UPDATE_CONTROL_OFS);
    wire wr_inc = req.wr && (inc_lane != 4'hF);
    wire wr_ofs = req.wr && (ofs_lane != 4'hF);
    wire transfer = req.wr && (req.addr == TRANSFER_CMD_OFS) && req.wdata[TRANSFER_BIT];
    wire commit = continuous_reg ? (wr_inc || wr_ofs) : transfer;
    wire [PHASE_W-1:0] inc_staged = wr_inc ? put_byte(stage_inc_reg, inc_lane[2:0], req.wdata) : stage_inc_reg;
    wire [PHASE_W-1:0] ofs_staged = wr_ofs ? put_byte(stage_ofs_reg, ofs_lane[2:0], req.wdata) : stage_ofs_reg;

    // Counter wraps to zero once it stands at the limit; a limit of zero holds it at zero
    assign counter_next = (counter_reg >= limit) ? COUNTER_RST : counter_reg + 4'h1;

    // Index source selection
    logic [3:0] index_sel;
    always_comb begin
        case (mode)
            MODE_REGISTER: index_sel = register_index_reg;
            MODE_B0_A0: index_sel = {2'b00, pin_level.b_zero, pin_level.a_zero};
            MODE_B1_A1: index_sel = {2'b00, pin_level.b_one, pin_level.a_one};
            MODE_A1_A0: index_sel = {2'b00, pin_level.a_one, pin_level.a_zero};
            MODE_B1_B0: index_sel = {2'b00, pin_level.b_one, pin_level.b_zero};
            MODE_B1A1B0A0: index_sel = {pin_level.b_one, pin_level.a_one, pin_level.b_zero, pin_level.a_zero};
            MODE_B1B0A1A0: index_sel = {pin_level.b_one, pin_level.b_zero, pin_level.a_one, pin_level.a_zero};
            default: index_sel = edge_mode ? counter_reg : register_index_reg;
        endcase
    end

    // Read mux; unmapped addresses and reserved bits read zero
    logic [DATA_W-1:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        if (req.addr == PROFILE_SELECT_CONTROL_OFS) rd_mux = select_control_reg;
        else if (req.addr == PHASE_UPDATE_CONTROL_OFS) rd_mux = {4'h0, phase_index_reg};
        else if (req.addr == REGISTER_INDEX_OFS) rd_mux = {4'h0, register_index_reg};
        else if (req.addr == UPDATE_CONTROL_OFS) rd_mux = {7'h00, continuous_reg};
        else if (req.addr == ACTIVE_STATUS_OFS) rd_mux = {4'h0, active_reg};
        else if (inc_lane != 4'hF) rd_mux = table_reg[phase_index_reg].increment[inc_lane[2:0]*8 +: 8];
        else if (ofs_lane != 4'hF) rd_mux = table_reg[phase_index_reg].offset[ofs_lane[2:0]*8 +: 8];
    end

    // Software-owned control registers
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            select_control_reg <= PROFILE_SELECT_CONTROL_RST;
            phase_index_reg <= PHASE_INDEX_RST;
            register_index_reg <= REGISTER_INDEX_RST;
            continuous_reg <= UPDATE_CONTINUOUS_RST;
        end else begin
            if (wr_ctrl) select_control_reg <= req.wdata;
            if (wr_phase_idx) phase_index_reg <= req.wdata[3:0];
            if (wr_reg_idx) register_index_reg <= req.wdata[3:0];
            if (wr_update) continuous_reg <= req.wdata[CONTINUOUS_BIT];
        end
    end

    // Edge counter; leaving the edge modes parks it at zero so re-entry starts clean
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            counter_reg <= COUNTER_RST;
            count_state_reg <= CNT_IDLE;
        end else begin
            case (count_state_reg)
                CNT_IDLE: begin
                    counter_reg <= COUNTER_RST;
                    if (edge_mode) count_state_reg <= CNT_RUN;
                end
                CNT_RUN: begin
                    if (!edge_mode) count_state_reg <= CNT_IDLE;
                    else if (edge_seen) counter_reg <= counter_next;
                end
                default: count_state_reg <= CNT_IDLE;
            endcase
        end
    end

    // Staging of phase bytes, then commit into the indexed profile
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            stage_inc_reg <= '0;
            stage_ofs_reg <= '0;
            for (int i = 0; i < NUM_PROF; i++) table_reg[i] <= '0;
        end else begin
            stage_inc_reg <= inc_staged;
            stage_ofs_reg <= ofs_staged;
            if (commit) table_reg[phase_index_reg] <= '{increment: inc_staged, offset: ofs_staged};
        end
    end

    // Registered outputs
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            active_reg <= 4'h0;
            rdata_reg <= 8'h00;
            inc_out_reg <= '0;
            ofs_out_reg <= '0;
        end else begin
            active_reg <= index_sel;
            rdata_reg <= req.rd ? rd_mux : 8'h00;
            inc_out_reg <= table_reg[index_sel].increment;
            ofs_out_reg <= table_reg[index_sel].offset;
        end
    end

    assign active_profile_o = active_reg;
    assign rdata_o = rdata_reg;
    assign active_increment_o = inc_out_reg;
    assign active_offset_o = ofs_out_reg;

    AST_REG_MODE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (mode == MODE_REGISTER) ##1 (mode == MODE_REGISTER) |-> active_reg == $past(register_index_reg))
        else $error("register index not followed");
    AST_MODE_ONE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (mode == MODE_B0_A0) |=> active_reg == {2'b00, $past(pin_level.b_zero), $past(pin_level.a_zero)})
        else $error("mode 1 index wrong");
    AST_MODE_THREE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (mode == MODE_A1_A0) |=> active_reg == {2'b00, $past(pin_level.a_one), $past(pin_level.a_zero)})
        else $error("mode 3 index wrong");
    AST_MODE_FIVE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (mode == MODE_B1A1B0A0) |=> active_reg == {$past(pin_level.b_one), $past(pin_level.a_one),
                                                   $past(pin_level.b_zero), $past(pin_level.a_zero)})
        else $error("mode 5 bit order wrong");
    AST_EDGE_STEP: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (count_state_reg == CNT_RUN && edge_mode && edge_seen && counter_reg < limit)
        |=> counter_reg == $past(counter_reg) + 4'h1)
        else $error("counter did not step on edge");
    AST_EDGE_WRAP: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (count_state_reg == CNT_RUN && edge_mode && edge_seen && counter_reg >= limit) |=> counter_reg == 4'h0)
        else $error("counter did not wrap at limit");
    AST_HOLD: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (count_state_reg == CNT_RUN && edge_mode && !edge_seen) |=> $stable(counter_reg))
        else $error("counter moved without edge");
    AST_RESERVED: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (req.rd && req.addr == PHASE_UPDATE_CONTROL_OFS) |=> rdata_o == {4'h0, $past(phase_index_reg)})
        else $error("reserved bits read nonzero");
    AST_HELD_UPDATE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (!continuous_reg && !transfer) |=> table_reg[$past(phase_index_reg)] == $past(table_reg[phase_index_reg]))
        else $error("profile changed without transfer");
endmodule

// ===== pin_controller.sv
// External controller model that steps the profile select pins
`timescale 1ns/1ps
module pin_controller #(
    parameter int HOLD_MIN = 2
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic slow_i,
    input wire profile_select_pkg::select_pins_type target_i,
    output profile_select_pkg::select_pins_type pins_o
);
    import profile_select_pkg::*;
    logic [3:0] hold_reg;
    wire [3:0] hold_min = slow_i ? 4'h6 : 4'(HOLD_MIN);
    // Each level stands its hold time first; shorter pulses could slip past the synchroniser
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pins_o <= '0;
            hold_reg <= 4'h0;
        end else if (target_i != pins_o && hold_reg >= hold_min) begin
            pins_o <= target_i;
            hold_reg <= 4'h0;
        end else if (hold_reg != 4'hF) begin
            hold_reg <= hold_reg + 4'h1;
        end
    end
endmodule

// ===== nco_profile_select_bench.sv
// Self-checking bench for the oscillator profile selector
`timescale 1ns/1ps
module nco_profile_select_bench;
    import profile_select_pkg::*;
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [ADDR_W-1:0] addr_i = '0;
    logic [DATA_W-1:0] wdata_i = '0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic slow = 1'b0;
    logic [DATA_W-1:0] rdata_o;
    select_pins_type target = '0;
    select_pins_type pins;
    logic [PROF_W-1:0] active_profile_o;
    logic [PHASE_W-1:0] active_increment_o, active_offset_o;
    int num_errors = 0;
    int n_tests = 0;
    int cycles = 0;
    int seed = 32'h2405;
    int mode, lim, cnt, k;
    logic [47:0] inc_v, ofs_v;
    logic [3:0] ridx;

    nco_profile_select #(.NUM_PROF(NUM_PROFILES)) DUT (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .select_pins_i(pins), .active_profile_o(active_profile_o),
        .active_increment_o(active_increment_o), .active_offset_o(active_offset_o));
    pin_controller PEER (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .slow_i(slow), .target_i(target),
        .pins_o(pins));

    initial begin
        forever #20 sys_clk_i = ~sys_clk_i;
    end
    // Hang guard: the sequence needs well under five thousand cycles
    always @(posedge sys_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            close_out();
        end
    end

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic note(input string what, input logic [47:0] exp, input logic [47:0] got);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One-cycle write strobe; a strobe left high would repeat the write and commit phase bytes twice
    task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        wr_i <= 1'b1;
        rd_i <= 1'b0;
        addr_i <= a;
        wdata_i <= d;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic idle(input int n);
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        repeat (n) @(posedge sys_clk_i);
    endtask
    task automatic chk_reg(input logic [11:0] a, input logic [7:0] exp);
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        #1;
        note("register read", {40'h0, exp}, {40'h0, rdata_o});
    endtask
    // Outputs are looked at just after the edge, once they have settled
    task automatic chk_prof(input logic [3:0] exp);
        #1;
        note("active profile", {44'h0, exp}, {44'h0, active_profile_o});
        chk_reg(ACTIVE_STATUS_OFS, {4'h0, exp});
    endtask
    task automatic chk_phase(input logic [47:0] ei, input logic [47:0] eo);
        #1;
        note("active increment", ei, active_increment_o);
        note("active offset", eo, active_offset_o);
    endtask
    // Worst case: six hold cycles in the peer plus four through the selector in the edge modes
    task automatic set_pins(input select_pins_type p);
        @(posedge sys_clk_i);
        target <= p;
        repeat (12) @(posedge sys_clk_i);
    endtask
    function automatic logic [3:0] exp_idx(input int m, input logic [3:0] r, input select_pins_type p);
        case (m)
            1: return {2'h0, p.b_zero, p.a_zero};
            2: return {2'h0, p.b_one, p.a_one};
            3: return {2'h0, p.a_one, p.a_zero};
            4: return {2'h0, p.b_one, p.b_zero};
            5: return {p.b_one, p.a_one, p.b_zero, p.a_zero};
            6: return {p.b_one, p.b_zero, p.a_one, p.a_zero};
            default: return r;
        endcase
    endfunction

    initial begin
        repeat (3) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        // Reset values, reserved nibble and an unmapped place
        chk_prof(4'h0);
        chk_reg(PROFILE_SELECT_CONTROL_OFS, 8'h00);
        chk_reg(PHASE_UPDATE_CONTROL_OFS, 8'h00);
        chk_reg(12'h000, 8'h00);
        wr_reg(PHASE_UPDATE_CONTROL_OFS, 8'hFF);
        chk_reg(PHASE_UPDATE_CONTROL_OFS, 8'h0F);
        // Every non-counting mode against random pins; spare codes fall back to the register
        for (int i = 0; i < 48; i++) begin
            mode = i % 16;
            if (mode >= 8 && mode <= 11) continue;
            ridx = 4'($random(seed));
            lim = $random(seed) & 15;
            slow <= 1'($random(seed));
            set_pins(select_pins_type'($random(seed)));
            wr_reg(REGISTER_INDEX_OFS, {4'h0, ridx});
            wr_reg(PROFILE_SELECT_CONTROL_OFS, {4'(mode), 4'(lim)});
            idle(4);
            chk_prof(exp_idx(mode, ridx, target));
            chk_reg(PROFILE_SELECT_CONTROL_OFS, {4'(mode), 4'(lim)});
        end
        // Edge counting on each pin, with limits 2, 0, 15 and 5; other pins must not count
        set_pins('0);
        for (int e = 0; e < 4; e++) begin
            lim = (e == 0) ? 2 : (e == 1) ? 0 : (e == 2) ? 15 : 5;
            wr_reg(PROFILE_SELECT_CONTROL_OFS, {4'(8 + e), 4'(lim)});
            idle(4);
            cnt = 0;
            for (int n = 0; n < 24; n++) begin
                k = ($random(seed) & 1) ? e : ($random(seed) & 3);
                set_pins(select_pins_type'(4'h1 << k));
                set_pins('0);
                if (k == e) cnt = (cnt >= lim) ? 0 : cnt + 1;
                chk_prof(4'(cnt));
            end
            wr_reg(PROFILE_SELECT_CONTROL_OFS, 8'h00);
        end
        // Phase words: first held back until the transfer command, then continuous
        wr_reg(UPDATE_CONTROL_OFS, 8'h00);
        for (int t = 0; t < 2; t++) begin
            ridx = 4'(3 + t * 7);
            inc_v = 48'({$random(seed), $random(seed)});
            ofs_v = 48'({$random(seed), $random(seed)});
            wr_reg(PHASE_UPDATE_CONTROL_OFS, {4'h0, ridx});
            for (int b = 0; b < 6; b++) begin
                wr_reg(INCREMENT_BASE_OFS + 12'(b), inc_v[8*b +: 8]);
                wr_reg(OFFSET_BASE_OFS + 12'(b), ofs_v[8*b +: 8]);
            end
            wr_reg(REGISTER_INDEX_OFS, {4'h0, ridx});
            idle(4);
            if (t == 0) begin
                chk_phase(48'h0, 48'h0);
                wr_reg(TRANSFER_CMD_OFS, 8'h01);
                idle(4);
            end
            chk_phase(inc_v, ofs_v);
            chk_reg(INCREMENT_BASE_OFS + 12'h5, inc_v[47:40]);
            wr_reg(UPDATE_CONTROL_OFS, 8'h01);
        end
        idle(2);
        close_out();
    end
endmodule
